/* File: hw/tlb_pkg.sv */
package tlb_pkg;
	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_PAGE_MASK = 8'h00;
	localparam logic [7:0] ADDR_KEY = 8'h04;
	localparam logic [7:0] ADDR_EVEN = 8'h08;
	localparam logic [7:0] ADDR_ODD = 8'h0C;
	localparam logic [7:0] ADDR_INDEX = 8'h10;
	localparam logic [7:0] ADDR_WIRED = 8'h14;
	localparam logic [7:0] ADDR_RANDOM = 8'h18;
	localparam logic [7:0] ADDR_CONTROL = 8'h1C;
	localparam logic [7:0] ADDR_MMID = 8'h20;
	localparam logic [7:0] ADDR_COMMAND = 8'h24;
	localparam logic [7:0] ADDR_STATUS = 8'h28;
	// ------------------------------------------------------------
	// Field layouts
	// ------------------------------------------------------------
	localparam int VPN_LSB = 13;
	localparam int VPN_W = 19;
	localparam int MASK_W = 16;
	localparam int TAG_W = 8;
	localparam int MMID_W = 32;
	localparam int PFN_LSB = 6;
	localparam int PFN_W = 20;
	localparam int C_LSB = 3;
	localparam int C_W = 3;
	localparam int BIT_RI = 31;
	localparam int BIT_XI = 30;
	localparam int BIT_D = 2;
	localparam int BIT_V = 1;
	localparam int BIT_G = 0;
	localparam int BIT_DM = 0;
	localparam int BIT_MIE = 1;
	localparam int CMD_PROBE = 0;
	localparam int CMD_READ = 1;
	localparam int CMD_WRITE_INDEXED = 2;
	localparam int CMD_WRITE_RANDOM = 3;
	localparam int BIT_MCHK = 0;
	localparam int BIT_PROBE_MISS = 31;
	// ------------------------------------------------------------
	// Constants
	// ------------------------------------------------------------
	localparam logic [31:0] DEBUG_LO = 32'hFF20_0000;
	localparam logic [31:0] DEBUG_HI = 32'hFF3F_FFFF;
	localparam logic [11:0] OFFSET_4K = 12'hFFF;
	localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage : tlb_pkg

/* File: hw/tlb_entry_array.sv */
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
// Operation
// - Debug window 0xFF200000..0xFF3FFFFF decoded in debug mode.
// - Window compared against exact lower and upper bounds.
// - Window active only while debug mode flag is set.
// - At least three entries are provided.
// - Two instruction and one data translation can coexist.
// - Sixteen entries by default, more by parameter.
// - Wired entries are never chosen by random replacement.
// - Entries hold address space tag; global bypasses its compare.
// - With identifier enable set, 32-bit map identifier replaces tag.
// - All entries compared in parallel, any entry any translation.
// - Compare part holds page pair number, tag, global, mask.
// - Two sub-entries: frame, valid, dirty, cache, inhibit flags.
// - Even sub-entry serves even page, odd sub-entry odd page.
// - Dirty and inhibit flags enforce read, write, execute policies.
// - Optional 1 kB page fields are omitted.
// - Entry fields mirror mask, key and two staging registers.
// - Multiple matches reported only on entry writes.
// - Probe writes match index, or negative value on miss.
// - Valid flag is not an entry initialised marker.
// - Match needs masked page compare and tag equal or global.
// - Bit just above the mask picks even or odd sub-entry.
// - Invalid sub-entry raises translation-invalid instead of address.
// - Store to clean valid page raises translation-modified.
module tlb_entry_array #(
	parameter int ENTRIES = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic lookup_valid,
	input wire logic [31:0] lookup_va,
	input wire logic lookup_store,
	input wire logic lookup_fetch,
	output logic xlat_done,
	output logic xlat_hit,
	output logic [31:0] xlat_pa,
	output logic [2:0] xlat_cache,
	output logic xlat_miss,
	output logic xlat_invalid,
	output logic xlat_modified,
	output logic xlat_debug_window,
	output logic [7:0] xlat_index
);
	import tlb_pkg::*;

	localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
	localparam logic [IW-1:0] LAST = IW'(ENTRIES - 1);

	// ------------------------------------------------------------
	// Staging and control registers
	// ------------------------------------------------------------
	logic [MASK_W-1:0] page_size_mask_register;
	logic [31:0] translation_key_register;
	logic [31:0] even_translation_staging;
	logic [31:0] odd_translation_staging;
	logic [31:0] index_register;
	logic [IW-1:0] wired;
	logic [IW-1:0] random;
	logic debug_mode_flag;
	logic map_identifier_enable;
	logic [MMID_W-1:0] memory_map_identifier;
	logic machine_check;

	// ------------------------------------------------------------
	// Entry storage
	// ------------------------------------------------------------
	// comparison section, then the even and odd sub-entry fields
	logic [VPN_W-1:0] virtual_page_pair_number [ENTRIES];
	logic [MMID_W-1:0] address_space_tag [ENTRIES];
	logic global_flag [ENTRIES];
	logic [MASK_W-1:0] entry_mask [ENTRIES];
	logic [PFN_W-1:0] even_frame_number [ENTRIES];
	logic [PFN_W-1:0] odd_frame_number [ENTRIES];
	logic [C_W-1:0] even_cache [ENTRIES];
	logic [C_W-1:0] odd_cache [ENTRIES];
	logic [ENTRIES-1:0] even_valid;
	logic [ENTRIES-1:0] odd_valid;
	logic [ENTRIES-1:0] even_dirty;
	logic [ENTRIES-1:0] odd_dirty;
	logic [ENTRIES-1:0] even_read_inhibit;
	logic [ENTRIES-1:0] odd_read_inhibit;
	logic [ENTRIES-1:0] even_execute_inhibit;
	logic [ENTRIES-1:0] odd_execute_inhibit;
	logic [ENTRIES-1:0] loaded;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic setup;
	logic wr;
	logic known;
	logic [31:0] rd_value;

	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	// Every access completes without wait states.
	assign pready = 1'b1;

	always_comb begin
		known = 1'b1;
		rd_value = RESET_ZERO;
		case (paddr)
			ADDR_PAGE_MASK: rd_value = 32'(page_size_mask_register) << VPN_LSB;
			ADDR_KEY: rd_value = translation_key_register;
			ADDR_EVEN: rd_value = even_translation_staging;
			ADDR_ODD: rd_value = odd_translation_staging;
			ADDR_INDEX: rd_value = index_register;
			ADDR_WIRED: rd_value = 32'(wired);
			ADDR_RANDOM: rd_value = 32'(random);
			ADDR_CONTROL: begin
				rd_value[BIT_DM] = debug_mode_flag;
				rd_value[BIT_MIE] = map_identifier_enable;
			end
			ADDR_MMID: rd_value = memory_map_identifier;
			ADDR_COMMAND: rd_value = RESET_ZERO;
			ADDR_STATUS: rd_value[BIT_MCHK] = machine_check;
			default: known = 1'b0;
		endcase
	end

	// Read data is captured in the setup cycle so it is a flop output
	// by the access cycle.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= RESET_ZERO;
			pslverr <= 1'b0;
		end else if (ce && setup) begin
			prdata <= pwrite ? RESET_ZERO : rd_value;
			pslverr <= ~known;
		end
	end

	logic cmd_probe;
	logic cmd_read;
	logic cmd_wi;
	logic cmd_wr;

	assign cmd_probe = wr && paddr == ADDR_COMMAND && pwdata[CMD_PROBE];
	assign cmd_read = wr && paddr == ADDR_COMMAND && pwdata[CMD_READ];
	assign cmd_wi = wr && paddr == ADDR_COMMAND && pwdata[CMD_WRITE_INDEXED];
	assign cmd_wr = wr && paddr == ADDR_COMMAND && pwdata[CMD_WRITE_RANDOM];

	// ------------------------------------------------------------
	// Parallel compare
	// ------------------------------------------------------------
	logic [MMID_W-1:0] current_tag;
	logic [VPN_W-1:0] key_vpn;
	logic [IW-1:0] target;
	logic [ENTRIES-1:0] look_match;
	logic [ENTRIES-1:0] probe_match;
	logic [ENTRIES-1:0] dup_match;

	// map identifier replaces the short tag
	assign current_tag = map_identifier_enable ? memory_map_identifier
		: MMID_W'(translation_key_register[TAG_W-1:0]);
	assign key_vpn = translation_key_register[31:VPN_LSB];
	assign target = cmd_wi ? index_register[IW-1:0] : random;

	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi++) begin : g_cmp
			logic [VPN_W-1:0] care;
			logic [VPN_W-1:0] dup_care;
			logic tag_ok;
			assign care = ~VPN_W'(entry_mask[gi]);
			assign dup_care = ~VPN_W'(entry_mask[gi] | page_size_mask_register);
			// global flag bypasses the tag compare
			assign tag_ok = global_flag[gi] || address_space_tag[gi] == current_tag;
			// masked page compare in every entry
			assign look_match[gi] = tag_ok
				&& ((virtual_page_pair_number[gi] ^ lookup_va[31:VPN_LSB]) & care) == '0;
			assign probe_match[gi] = tag_ok
				&& ((virtual_page_pair_number[gi] ^ key_vpn) & care) == '0;
			assign dup_match[gi] = loaded[gi] && (tag_ok || (even_translation_staging[BIT_G]
				&& odd_translation_staging[BIT_G]))
				&& ((virtual_page_pair_number[gi] ^ key_vpn) & dup_care) == '0
				&& IW'(gi) != target;
		end
	endgenerate

	logic look_any;
	logic [IW-1:0] look_idx;
	logic probe_any;
	logic [IW-1:0] probe_idx;

	// Lowest index wins; software keeps keys unique so ties do not occur.
	always_comb begin
		look_any = 1'b0;
		look_idx = '0;
		probe_any = 1'b0;
		probe_idx = '0;
		for (int i = ENTRIES - 1; i >= 0; i--) begin
			if (look_match[i]) begin
				look_any = 1'b1;
				look_idx = IW'(i);
			end
			if (probe_match[i]) begin
				probe_any = 1'b1;
				probe_idx = IW'(i);
			end
		end
	end

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			page_size_mask_register <= '0;
			translation_key_register <= RESET_ZERO;
			memory_map_identifier <= RESET_ZERO;
			debug_mode_flag <= 1'b0;
			map_identifier_enable <= 1'b0;
		end else if (ce && wr) begin
			if (paddr == ADDR_PAGE_MASK) begin
				page_size_mask_register <= pwdata[VPN_LSB +: MASK_W];
			end
			if (paddr == ADDR_KEY) begin
				translation_key_register <= pwdata;
			end
			if (paddr == ADDR_MMID) begin
				memory_map_identifier <= pwdata;
			end
			if (paddr == ADDR_CONTROL) begin
				debug_mode_flag <= pwdata[BIT_DM];
				map_identifier_enable <= pwdata[BIT_MIE];
			end
			// entry read reloads mask and key
			if (cmd_read) begin
				page_size_mask_register <= entry_mask[index_register[IW-1:0]];
				translation_key_register <= {virtual_page_pair_number[index_register[IW-1:0]],
					VPN_LSB'(address_space_tag[index_register[IW-1:0]][TAG_W-1:0])};
			end
		end
	end

	// entry read refills the staging registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			even_translation_staging <= RESET_ZERO;
			odd_translation_staging <= RESET_ZERO;
		end else if (ce && cmd_read) begin
			even_translation_staging <= {even_read_inhibit[index_register[IW-1:0]],
				even_execute_inhibit[index_register[IW-1:0]], 4'h0,
				even_frame_number[index_register[IW-1:0]],
				even_cache[index_register[IW-1:0]],
				even_dirty[index_register[IW-1:0]],
				even_valid[index_register[IW-1:0]],
				global_flag[index_register[IW-1:0]]};
			odd_translation_staging <= {odd_read_inhibit[index_register[IW-1:0]],
				odd_execute_inhibit[index_register[IW-1:0]], 4'h0,
				odd_frame_number[index_register[IW-1:0]],
				odd_cache[index_register[IW-1:0]],
				odd_dirty[index_register[IW-1:0]],
				odd_valid[index_register[IW-1:0]],
				global_flag[index_register[IW-1:0]]};
		end else if (ce && wr && paddr == ADDR_EVEN) begin
			even_translation_staging <= pwdata;
		end else if (ce && wr && paddr == ADDR_ODD) begin
			odd_translation_staging <= pwdata;
		end
	end

	// probe result lands in the index register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			index_register <= RESET_ZERO;
		end else if (ce && cmd_probe) begin
			index_register <= probe_any ? 32'(probe_idx) : (32'h1 << BIT_PROBE_MISS);
		end else if (ce && wr && paddr == ADDR_INDEX) begin
			index_register <= 32'(pwdata[IW-1:0]);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wired <= '0;
			random <= LAST;
		end else if (ce) begin
			if (wr && paddr == ADDR_WIRED) begin
				wired <= pwdata[IW-1:0];
				random <= LAST;
			end else if (random <= wired || random == '0) begin
				random <= LAST;
			end else begin
				random <= random - IW'(1);
			end
		end
	end

	logic write_req;

	assign write_req = cmd_wi | cmd_wr;

	// duplicate keys flagged only on entry writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			machine_check <= 1'b0;
		end else if (ce) begin
			if (write_req && |dup_match) begin
				machine_check <= 1'b1;
			end else if (wr && paddr == ADDR_STATUS && pwdata[BIT_MCHK]) begin
				machine_check <= 1'b0;
			end
		end
	end

	// Software cannot see this marker. It only keeps the duplicate check away
	// from entries that were never filled, whose contents are undefined.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			loaded <= '0;
		end else if (ce && write_req && !(|dup_match)) begin
			loaded[target] <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Entry write
	// ------------------------------------------------------------
	// entries carry no reset; software initialises them.
	// valid flags are page flags, no hidden init marker.
	always_ff @(posedge clk) begin
		if (ce && write_req && !(|dup_match)) begin
			// fields come from mask, key and staging registers
			virtual_page_pair_number[target] <= key_vpn;
			address_space_tag[target] <= current_tag;
			global_flag[target] <= even_translation_staging[BIT_G]
				& odd_translation_staging[BIT_G];
			entry_mask[target] <= page_size_mask_register;
			even_frame_number[target] <= even_translation_staging[PFN_LSB +: PFN_W];
			odd_frame_number[target] <= odd_translation_staging[PFN_LSB +: PFN_W];
			even_cache[target] <= even_translation_staging[C_LSB +: C_W];
			odd_cache[target] <= odd_translation_staging[C_LSB +: C_W];
			even_valid[target] <= even_translation_staging[BIT_V];
			odd_valid[target] <= odd_translation_staging[BIT_V];
			even_dirty[target] <= even_translation_staging[BIT_D];
			odd_dirty[target] <= odd_translation_staging[BIT_D];
			even_read_inhibit[target] <= even_translation_staging[BIT_RI];
			odd_read_inhibit[target] <= odd_translation_staging[BIT_RI];
			even_execute_inhibit[target] <= even_translation_staging[BIT_XI];
			odd_execute_inhibit[target] <= odd_translation_staging[BIT_XI];
		end
	end

	// ------------------------------------------------------------
	// Translation path
	// ------------------------------------------------------------
	logic [31:0] offset_mask;
	logic odd_page;
	logic in_window;
	logic sel_valid;
	logic sel_dirty;
	logic sel_ri;
	logic sel_xi;
	logic [PFN_W-1:0] sel_pfn;
	logic [C_W-1:0] sel_cache;
	logic is_load;

	assign offset_mask = {4'h0, entry_mask[look_idx], OFFSET_4K};
	// the bit just above the page offset picks the half
	assign odd_page = |(lookup_va & (offset_mask + 32'h1));
	assign in_window = debug_mode_flag && lookup_va >= DEBUG_LO && lookup_va <= DEBUG_HI;
	assign is_load = ~lookup_store & ~lookup_fetch;

	// even sub-entry for even page, odd for odd page
	always_comb begin
		if (odd_page) begin
			sel_valid = odd_valid[look_idx];
			sel_dirty = odd_dirty[look_idx];
			sel_ri = odd_read_inhibit[look_idx];
			sel_xi = odd_execute_inhibit[look_idx];
			sel_pfn = odd_frame_number[look_idx];
			sel_cache = odd_cache[look_idx];
		end else begin
			sel_valid = even_valid[look_idx];
			sel_dirty = even_dirty[look_idx];
			sel_ri = even_read_inhibit[look_idx];
			sel_xi = even_execute_inhibit[look_idx];
			sel_pfn = even_frame_number[look_idx];
			sel_cache = even_cache[look_idx];
		end
	end

	// result registered one clock after the address
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			xlat_done <= 1'b0;
			xlat_hit <= 1'b0;
			xlat_pa <= RESET_ZERO;
			xlat_cache <= '0;
			xlat_miss <= 1'b0;
			xlat_invalid <= 1'b0;
			xlat_modified <= 1'b0;
			xlat_debug_window <= 1'b0;
			xlat_index <= '0;
		end else if (ce) begin
			xlat_done <= lookup_valid;
			xlat_hit <= 1'b0;
			xlat_miss <= 1'b0;
			xlat_invalid <= 1'b0;
			xlat_modified <= 1'b0;
			xlat_debug_window <= 1'b0;
			if (lookup_valid) begin
				xlat_index <= 8'(look_idx);
				if (in_window) begin
					xlat_debug_window <= 1'b1;
				end else if (!look_any) begin
					xlat_miss <= 1'b1;
				end else if (!sel_valid) begin
					xlat_invalid <= 1'b1;
				end else if ((sel_ri && is_load) || (sel_xi && lookup_fetch)) begin
					xlat_invalid <= 1'b1;
				end else if (lookup_store && !sel_dirty) begin
					xlat_modified <= 1'b1;
				end else begin
					xlat_hit <= 1'b1;
					xlat_cache <= sel_cache;
					xlat_pa <= ({sel_pfn, OFFSET_4K} & ~offset_mask & ~32'(OFFSET_4K))
						| (lookup_va & offset_mask);
				end
			end
		end
	end

	// ENTRIES defaults to sixteen; keep it
	// at three or more. Only 4 kB and larger pages are supported.
endmodule : tlb_entry_array

/* File: dv/tlb_entry_array_properties.sv */
`timescale 1ns/1ns
module tlb_entry_array_properties #(
	parameter int ENTRIES = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic lookup_valid,
	input wire logic [31:0] lookup_va,
	input wire logic lookup_store,
	input wire logic xlat_done,
	input wire logic xlat_hit,
	input wire logic [31:0] xlat_pa,
	input wire logic xlat_miss,
	input wire logic xlat_invalid,
	input wire logic xlat_modified,
	input wire logic xlat_debug_window
);
	import tlb_pkg::*;
	logic [4:0] outcome;
	logic [31:0] prev_va;
	assign outcome = {xlat_hit, xlat_miss, xlat_invalid, xlat_modified, xlat_debug_window};
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev_va <= 32'h0;
		end else begin
			prev_va <= lookup_va;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	chk_done_latency: assert property (lookup_valid && ce |=> xlat_done)
		else $error("Lookup not answered one cycle later.");
	chk_done_cause: assert property (xlat_done |-> $past(lookup_valid))
		else $error("Result given without a lookup.");
	chk_single_outcome: assert property (xlat_done |-> $onehot(outcome))
		else $error("Lookup result is not exactly one outcome.");
	chk_outcome_framed: assert property (outcome != 5'h0 |-> xlat_done)
		else $error("Outcome flag outside a result cycle.");
	chk_window_inside: assert property (xlat_debug_window |-> (prev_va >= DEBUG_LO && prev_va <= DEBUG_HI))
		else $error("Debug window flagged outside its bounds.");
	chk_window_outside: assert property (lookup_valid && (lookup_va < DEBUG_LO || lookup_va > DEBUG_HI) |=> !xlat_debug_window)
		else $error("Address outside the window decoded as debug.");
	chk_modified_store: assert property (xlat_modified |-> $past(lookup_store))
		else $error("Modified flag raised for a non-store.");
	chk_hit_offset: assert property (xlat_hit |-> xlat_pa[11:0] == prev_va[11:0])
		else $error("Page offset not carried into the physical address.");
	chk_ready_nowait: assert property (psel && penable |-> pready)
		else $error("Register access stalled.");
	chk_unmapped_err: assert property (psel && penable && paddr > ADDR_STATUS |-> pslverr)
		else $error("Unmapped register access not refused.");
	cover property (xlat_hit);
	cover property (xlat_debug_window);
	cover property (xlat_modified);
	cover property (psel && penable && pslverr);
endmodule : tlb_entry_array_properties
bind tlb_entry_array tlb_entry_array_properties #(.ENTRIES(ENTRIES)) i_tlb_entry_array_properties (
	.clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .lookup_valid(lookup_valid), .lookup_va(lookup_va),
	.lookup_store(lookup_store), .xlat_done(xlat_done), .xlat_hit(xlat_hit), .xlat_pa(xlat_pa),
	.xlat_miss(xlat_miss), .xlat_invalid(xlat_invalid), .xlat_modified(xlat_modified),
	.xlat_debug_window(xlat_debug_window)
);

/* File: dv/lookup_source.sv */
`timescale 1ns/1ns
module lookup_source (
	input wire logic clk,
	output logic lookup_valid,
	output logic [31:0] lookup_va,
	output logic lookup_store,
	output logic lookup_fetch,
	input wire logic xlat_done,
	input wire logic xlat_hit,
	input wire logic [31:0] xlat_pa,
	input wire logic xlat_miss,
	input wire logic xlat_invalid,
	input wire logic xlat_modified,
	input wire logic xlat_debug_window,
	input wire logic [7:0] xlat_index
);
	initial begin
		lookup_valid = 1'h0;
		lookup_va = 32'h0;
		lookup_store = 1'h0;
		lookup_fetch = 1'h0;
	end
	// The address is inverted on release so a stale address never passes for a fresh one.
	task automatic issue(input logic [31:0] va, input logic st, input logic fe,
			output logic [4:0] o, output logic [31:0] pa, output logic [7:0] ix);
		@(posedge clk);
		lookup_valid <= 1'h1;
		lookup_va <= va;
		lookup_store <= st;
		lookup_fetch <= fe;
		@(posedge clk);
		lookup_valid <= 1'h0;
		lookup_va <= ~va;
		@(negedge clk);
		o = {xlat_hit, xlat_miss, xlat_invalid, xlat_modified, xlat_debug_window};
		if (xlat_done !== 1'h1) begin
			o = 5'h1F;
		end
		pa = xlat_pa;
		ix = xlat_index;
	endtask : issue
endmodule : lookup_source

/* File: dv/test_tlb_entry_array.sv */
`timescale 1ns/1ns
module test_tlb_entry_array;
	import tlb_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int N = 4;
	localparam logic [4:0] H = 5'h10;
	localparam logic [4:0] M = 5'h08;
	localparam logic [4:0] I = 5'h04;
	localparam logic [4:0] D = 5'h02;
	localparam logic [4:0] W = 5'h01;
	localparam logic [31:0] K0 = 32'h0002_0005;
	logic clk, nrst, ce, psel, penable, pwrite, pready, pslverr, se;
	logic lookup_valid, lookup_store, lookup_fetch, xlat_done, xlat_hit, xlat_miss;
	logic xlat_invalid, xlat_modified, xlat_debug_window;
	logic [7:0] paddr, xlat_index, x;
	logic [31:0] pwdata, prdata, rd, lookup_va, xlat_pa, p;
	logic [2:0] xlat_cache;
	logic [4:0] res;
	int err_count, n_compared;
	tlb_entry_array #(.ENTRIES(N)) i_tlb_entry_array (
		.clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lookup_valid(lookup_valid), .lookup_va(lookup_va), .lookup_store(lookup_store),
		.lookup_fetch(lookup_fetch), .xlat_done(xlat_done), .xlat_hit(xlat_hit),
		.xlat_pa(xlat_pa), .xlat_cache(xlat_cache), .xlat_miss(xlat_miss),
		.xlat_invalid(xlat_invalid), .xlat_modified(xlat_modified),
		.xlat_debug_window(xlat_debug_window), .xlat_index(xlat_index)
	);
	lookup_source i_lookup_source (
		.clk(clk), .lookup_valid(lookup_valid), .lookup_va(lookup_va),
		.lookup_store(lookup_store), .lookup_fetch(lookup_fetch), .xlat_done(xlat_done),
		.xlat_hit(xlat_hit), .xlat_pa(xlat_pa), .xlat_miss(xlat_miss),
		.xlat_invalid(xlat_invalid), .xlat_modified(xlat_modified),
		.xlat_debug_window(xlat_debug_window), .xlat_index(xlat_index)
	);
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			err_count++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) begin
			@(posedge clk);
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
		apb(1'h0, a, 32'h0);
		check(rd, want);
	endtask : rdchk
	function automatic logic [31:0] tr(input logic [1:0] rx, input logic [19:0] f,
			input logic [2:0] dvg);
		return {rx, 4'h0, f, 3'h3, dvg};
	endfunction : tr
	task automatic put(input logic [7:0] ix, input logic [31:0] k, input logic [31:0] ev,
			input logic [31:0] od);
		apb(1'h1, ADDR_PAGE_MASK, 32'h0);
		apb(1'h1, ADDR_KEY, k);
		apb(1'h1, ADDR_EVEN, ev);
		apb(1'h1, ADDR_ODD, od);
		apb(1'h1, ADDR_INDEX, {24'h0, ix});
		apb(1'h1, ADDR_COMMAND, 32'h1 << CMD_WRITE_INDEXED);
	endtask : put
	task automatic look(input logic [31:0] va, input logic [1:0] sf, input logic [4:0] o,
			input logic [31:0] pa, input logic [7:0] ix);
		i_lookup_source.issue(va, sf[1], sf[0], res, p, x);
		check({27'h0, res}, {27'h0, o});
		if (o == H) begin
			check(p, pa);
			check({29'h0, xlat_cache}, 32'h3);
		end
		if (o != M && o != W) begin
			check({24'h0, x}, {24'h0, ix});
		end
	endtask : look
	// ------------------------------------------------------------
	// Clock, watchdog and tests
	// ------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		final_report();
	end
	initial begin
		nrst = 1'h0;
		ce = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		rdchk(ADDR_CONTROL, 32'h0);
		rdchk(ADDR_WIRED, 32'h0);
		rdchk(ADDR_STATUS, 32'h0);
		rdchk(8'h40, 32'h0);
		check({31'h0, se}, 32'h1);
		$display("end of reset test");
		put(8'h0, K0, tr(2'h0, 20'h12345, 3'h6), tr(2'h0, 20'h54321, 3'h2));
		put(8'h1, 32'h0004_0009, tr(2'h2, 20'h0ABCD, 3'h7), tr(2'h1, 20'h0DCBA, 3'h7));
		put(8'h2, 32'h0006_0005, 32'h0, 32'h0);
		put(8'h3, 32'h0008_0005, 32'h0, 32'h0);
		rdchk(ADDR_EVEN, 32'h0);
		look(32'h0002_0ABC, 2'h0, H, 32'h1234_5ABC, 8'h0);
		look(32'h0002_1ABC, 2'h0, H, 32'h5432_1ABC, 8'h0);
		look(32'h0002_1004, 2'h2, D, 32'h0, 8'h0);
		look(32'h0002_0004, 2'h2, H, 32'h1234_5004, 8'h0);
		look(32'h0004_0010, 2'h0, I, 32'h0, 8'h1);
		look(32'h0004_0010, 2'h1, H, 32'h0ABC_D010, 8'h1);
		look(32'h0004_1010, 2'h1, I, 32'h0, 8'h1);
		look(32'h0004_1010, 2'h2, H, 32'h0DCB_A010, 8'h1);
		look(32'h0006_0000, 2'h0, I, 32'h0, 8'h2);
		look(32'h000A_0000, 2'h0, M, 32'h0, 8'h0);
		$display("end of lookup test");
		apb(1'h1, ADDR_INDEX, 32'h0);
		apb(1'h1, ADDR_COMMAND, 32'h1 << CMD_READ);
		rdchk(ADDR_EVEN, tr(2'h0, 20'h12345, 3'h6));
		rdchk(ADDR_KEY, K0);
		apb(1'h1, ADDR_COMMAND, 32'h1 << CMD_PROBE);
		rdchk(ADDR_INDEX, 32'h0);
		apb(1'h1, ADDR_KEY, 32'hFE00_0005);
		apb(1'h1, ADDR_COMMAND, 32'h1 << CMD_PROBE);
		rdchk(ADDR_INDEX, 32'h8000_0000);
		apb(1'h1, ADDR_KEY, 32'h0002_0006);
		look(32'h0002_0000, 2'h0, M, 32'h0, 8'h0);
		look(32'h0004_1010, 2'h2, H, 32'h0DCB_A010, 8'h1);
		$display("end of probe test");
		apb(1'h1, ADDR_CONTROL, 32'h1);
		look(32'hFF1F_FFFF, 2'h0, M, 32'h0, 8'h0);
		look(32'hFF20_0000, 2'h0, W, 32'h0, 8'h0);
		look(32'hFF3F_FFFF, 2'h1, W, 32'h0, 8'h0);
		look(32'hFF40_0000, 2'h0, M, 32'h0, 8'h0);
		apb(1'h1, ADDR_CONTROL, 32'h0);
		look(32'hFF20_0000, 2'h0, M, 32'h0, 8'h0);
		$display("end of debug window test");
		apb(1'h1, ADDR_KEY, K0);
		apb(1'h1, ADDR_INDEX, 32'h3);
		apb(1'h1, ADDR_COMMAND, 32'h1 << CMD_WRITE_INDEXED);
		rdchk(ADDR_STATUS, 32'h1);
		apb(1'h1, ADDR_STATUS, 32'h1);
		rdchk(ADDR_STATUS, 32'h0);
		look(32'h0008_0000, 2'h0, I, 32'h0, 8'h3);
		apb(1'h1, ADDR_CONTROL, 32'h2);
		apb(1'h1, ADDR_MMID, 32'h1234_5678);
		put(8'h1, 32'h000C_0005, tr(2'h0, 20'h00777, 3'h6), 32'h0);
		look(32'h000C_0004, 2'h0, H, 32'h0077_7004, 8'h1);
		apb(1'h1, ADDR_MMID, 32'h1234_5679);
		look(32'h000C_0004, 2'h0, M, 32'h0, 8'h0);
		apb(1'h1, ADDR_CONTROL, 32'h0);
		$display("end of identifier test");
		apb(1'h1, ADDR_WIRED, 32'h2);
		rdchk(ADDR_WIRED, 32'h2);
		apb(1'h0, ADDR_RANDOM, 32'h0);
		check({31'h0, rd >= 32'h2 && rd <= 32'h3}, 32'h1);
		apb(1'h1, ADDR_KEY, 32'h000A_0005);
		apb(1'h1, ADDR_EVEN, tr(2'h0, 20'h00ABC, 3'h6));
		apb(1'h1, ADDR_COMMAND, 32'h1 << CMD_WRITE_RANDOM);
		i_lookup_source.issue(32'h000A_0008, 1'h0, 1'h0, res, p, x);
		check({27'h0, res}, {27'h0, H});
		check({31'h0, x >= 8'h2 && x <= 8'h3}, 32'h1);
		@(posedge clk);
		ce <= 1'h0;
		i_lookup_source.issue(32'h000A_0008, 1'h0, 1'h0, res, p, x);
		check({27'h0, res}, 32'h1F);
		@(posedge clk);
		ce <= 1'h1;
		$display("end of replacement test");
		final_report();
	end
endmodule : test_tlb_entry_array
